// ---- rtl/lcdpm_top.sv ----
// The implementer's own choices: the address-and-strobe port and the register offsets.
`include "lcdpm_params.svh"
`default_nettype none
module lcdpm_top (
    // clock, reset, enable
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // register port
    input wire lcdpm_pkg::lcdpm_addr_t reg_addr,
    input wire lcdpm_pkg::lcdpm_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // pin function steering
    output logic [45:0] segment_line_lcd_sel,
    output logic [45:0] segment_line_com0_pixel
);
    import lcdpm_pkg::*;

    // register map, as seen on the plain register port:
    // segment enables sit in one window from the segment base,
    // pixel bytes in a second window from the pixel base;
    // every other index is unmapped: writes vanish, reads give zero

    // reset synchroniser: asserts at once, releases on the second edge
    logic rst_sync1_ff;
    logic rst_n_ff;

    // segment enable storage, flattened for the pin side
    lcdpm_byte_t seg_en_ff [`LCDPM_SEG_EN_CNT];
    logic [47:0] seg_en_flat;

    // register port decode, segment window
    logic [6:0] seg_off;
    logic seg_win;
    logic [2:0] seg_sel;
    logic [`LCDPM_SEG_EN_CNT-1:0] seg_hit_wr;
    logic seg_hit_rd;

    // register port decode, pixel window
    logic [6:0] pix_off;
    logic pix_win;
    lcdpm_pix_idx_t pix_idx;
    lcdpm_pix_idx_t pix_rd_idx;
    logic pix_hit_wr;
    logic pix_hit_rd;

    // pixel storage and read-back path
    logic [15:0] com0_bits;
    logic [7:0] pix_rd_data;
    logic [7:0] nxt_ctl_rdata;
    logic [7:0] ctl_rdata_ff;
    logic rd_is_pix_ff;

    // reset release through two flops; async assert keeps pins safe at once
    // the clock enable is left out here on purpose: a frozen block must
    // still leave reset cleanly, so the enable only gates the registers
    // the first flop is read by the second one and by nothing else
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync1_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_sync1_ff <= 1'b1;
            rst_n_ff <= rst_sync1_ff;
        end
    end

    // segment window: the offset from the base picks the register
    // a wrapped subtraction keeps indices below the base out of the window
    assign seg_off = reg_addr - `LCDPM_SEG_EN_BASE;
    assign seg_win = seg_off < 7'(`LCDPM_SEG_EN_CNT);
    assign seg_sel = seg_off[2:0];
    assign seg_hit_rd = reg_rd && seg_win;

    // pixel window: forty-eight bytes from the pixel base
    // the lower bound guards the wrap, since this base is not at zero
    assign pix_off = reg_addr - `LCDPM_PIX_BASE;
    assign pix_win = (reg_addr >= `LCDPM_PIX_BASE)
                     && (pix_off < 7'(`LCDPM_PIX_CNT));
    assign pix_idx = pix_off[5:0];
    assign pix_hit_wr = reg_wr && pix_win;
    assign pix_hit_rd = reg_rd && pix_win;

    // read index parked at zero outside the window
    // the memory has no bytes past forty-seven, so an idle or unmapped
    // index must never reach its read port
    assign pix_rd_idx = pix_win ? pix_idx : 6'h00;

    // segment enable registers, one generate entry per register
    // the sixth one has only six segments behind it, so its top bits
    // are masked on write and can never read back as one
    for (genvar g = 0; g < `LCDPM_SEG_EN_CNT; g++) begin : g_seg_en
        localparam logic [7:0] WMASK = (g == `LCDPM_SEG_EN_CNT - 1) ?
                                       `LCDPM_SEG5_MASK : 8'hFF;

        // one strobe per register, straight from the window decode
        assign seg_hit_wr[g] = reg_wr && seg_win && (seg_sel == 3'(g));

        // held while the enable is low; a write then is simply lost
        always_ff @(posedge clk or negedge rst_n_ff) begin
            if (!rst_n_ff) begin
                seg_en_ff[g] <= `LCDPM_SEG_EN_RST;
            end else if (ce && seg_hit_wr[g]) begin
                seg_en_ff[g] <= reg_wdata & WMASK;
            end
        end

        // eight ascending segments per register
        assign seg_en_flat[g*8 +: 8] = seg_en_ff[g];
    end

    // pin owner per segment line; a set enable hands the pin to the lcd
    // no other source is or-ed in, so nothing outside can take the pin back
    // limitation: the two top bits of the flat view have no pin at all
    for (genvar s = 0; s < `LCDPM_SEG_CNT; s++) begin : g_seg_line
        assign segment_line_lcd_sel[s] = seg_en_flat[s];
    end

    // common-0 pixel values exist for segments 0..15 only
    // the other segment lines are tied to zero here and never show a common-0 pixel
    for (genvar p = 0; p < `LCDPM_SEG_CNT; p++) begin : g_com0_line
        if (p < 2 * `LCDPM_SEG_PER_REG) begin : g_mapped
            assign segment_line_com0_pixel[p] = com0_bits[p];
        end else begin : g_unmapped
            assign segment_line_com0_pixel[p] = 1'b0;
        end
    end

    // pixel bytes live in their own memory with a registered read port
    // write and read decode the same window; with both strobes at once the read gets the old byte
    lcdpm_pix_mem u_pix_mem (
        .clk(clk),
        .rst_n(rst_n_ff),
        .ce(ce),
        .wr_en(pix_hit_wr),
        .wr_idx(pix_idx),
        .wr_data(reg_wdata),
        .rd_idx(pix_rd_idx),
        .rd_data_ff(pix_rd_data),
        .com0_bits(com0_bits)
    );

    // read select for the enable registers
    // a case keeps the index in range instead of reading past the array end
    always_comb begin
        nxt_ctl_rdata = `LCDPM_RD_RST;
        if (seg_hit_rd) begin
            case (seg_sel)
                3'h0: begin
                    nxt_ctl_rdata = seg_en_ff[0];
                end
                3'h1: begin
                    nxt_ctl_rdata = seg_en_ff[1];
                end
                3'h2: begin
                    nxt_ctl_rdata = seg_en_ff[2];
                end
                3'h3: begin
                    nxt_ctl_rdata = seg_en_ff[3];
                end
                3'h4: begin
                    nxt_ctl_rdata = seg_en_ff[4];
                end
                3'h5: begin
                    nxt_ctl_rdata = seg_en_ff[5];
                end
                default: begin
                    nxt_ctl_rdata = `LCDPM_RD_RST;
                end
            endcase
        end
    end

    // remembers which source answers the read in the next cycle
    // held while the enable is low so a frozen read keeps its answer
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            rd_is_pix_ff <= 1'b0;
        end else if (ce) begin
            rd_is_pix_ff <= pix_hit_rd;
        end
    end

    // control-side read data; unmapped indices answer zero
    // registered so the read answer comes from a flop like the pixel side
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ctl_rdata_ff <= `LCDPM_RD_RST;
        end else if (ce) begin
            ctl_rdata_ff <= nxt_ctl_rdata;
        end
    end

    // both sources are flop outputs; this only selects between them
    // trade-off: one mux level after the flops instead of a third flop,
    // which would push the read answer a cycle later than promised
    assign reg_rdata = rd_is_pix_ff ? pix_rd_data : ctl_rdata_ff;
endmodule : lcdpm_top
`default_nettype wire

// ---- rtl/lcdpm_params.svh ----
`ifndef LCDPM_PARAMS_SVH
`define LCDPM_PARAMS_SVH
// register indices on the plain register port
`define LCDPM_SEG_EN_BASE 7'h00
`define LCDPM_SEG_EN_CNT 6
`define LCDPM_PIX_BASE 7'h10
`define LCDPM_PIX_CNT 48
// field layout
`define LCDPM_SEG_PER_REG 8
`define LCDPM_SEG_CNT 46
`define LCDPM_SEG5_MASK 8'h3F
// reset values
`define LCDPM_SEG_EN_RST 8'h00
`define LCDPM_PIX_RST 8'h00
`define LCDPM_RD_RST 8'h00
`endif

// ---- rtl/lcdpm_pkg.sv ----
`default_nettype none
package lcdpm_pkg;
    typedef logic [6:0] lcdpm_addr_t;
    typedef logic [7:0] lcdpm_byte_t;
    typedef logic [5:0] lcdpm_pix_idx_t;
endpackage : lcdpm_pkg
`default_nettype wire

// ---- rtl/lcdpm_pix_mem.sv ----
`include "lcdpm_params.svh"
`default_nettype none
// pixel data storage, registered read port
module lcdpm_pix_mem (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // write side
    input wire logic wr_en,
    input wire lcdpm_pkg::lcdpm_pix_idx_t wr_idx,
    input wire lcdpm_pkg::lcdpm_byte_t wr_data,
    // read side
    input wire lcdpm_pkg::lcdpm_pix_idx_t rd_idx,
    output logic [7:0] rd_data_ff,
    // live view of the two common-0 bytes for the segment drivers
    output logic [15:0] com0_bits
);
    import lcdpm_pkg::*;

    lcdpm_byte_t mem_ff [`LCDPM_PIX_CNT];

    // storage: one byte per index, each bit its own seg/com pairing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `LCDPM_PIX_CNT; i++) begin
                mem_ff[i] <= `LCDPM_PIX_RST;
            end
        end else if (ce && wr_en) begin
            mem_ff[wr_idx] <= wr_data;
        end
    end

    // read data leave from a flip-flop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_ff <= `LCDPM_RD_RST;
        end else if (ce) begin
            rd_data_ff <= mem_ff[rd_idx];
        end
    end

    assign com0_bits = {mem_ff[1], mem_ff[0]};
endmodule : lcdpm_pix_mem
`default_nettype wire

// ---- verif/lcdpm_props.sv ----
`default_nettype none
module lcdpm_props (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // register port
    input wire lcdpm_pkg::lcdpm_addr_t reg_addr,
    input wire lcdpm_pkg::lcdpm_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // pin steering
    input wire logic [45:0] segment_line_lcd_sel,
    input wire logic [45:0] segment_line_com0_pixel
);
    import lcdpm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // one domain, so clock and reset are stated once
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_seg_write: assert property (reg_wr && ce && reg_addr < 7'h05 |=>
        segment_line_lcd_sel[$past(reg_addr) * 8 +: 8] == $past(reg_wdata)) else $error("seg");
    a_top_bits: assert property (reg_wr && ce && reg_addr == 7'h05 |=>
        segment_line_lcd_sel[45:40] == $past(reg_wdata[5:0])) else $error("top");
    a_top_rd: assert property (reg_rd && ce && reg_addr == 7'h05 |=>
        reg_rdata[7:6] == 2'h0) else $error("top read");
    a_pix_low: assert property (reg_wr && ce && reg_addr == 7'h10 |=>
        segment_line_com0_pixel[7:0] == $past(reg_wdata)) else $error("pix");
    a_pix_unique: assert property (reg_wr && ce && reg_addr == 7'h11 |=>
        segment_line_com0_pixel[15:8] == $past(reg_wdata)
        && $stable(segment_line_com0_pixel[7:0])
        && segment_line_com0_pixel[45:16] == 30'h0) else $error("pix upper");
    a_ce_freeze: assert property (!ce |=>
        $stable(segment_line_lcd_sel) && $stable(segment_line_com0_pixel)) else $error("frozen");
    a_rd_pix: assert property (reg_rd && ce && reg_addr == 7'h10 |=>
        reg_rdata == $past(segment_line_com0_pixel[7:0])) else $error("rd");
endmodule : lcdpm_props
`default_nettype wire

// ---- verif/lcdpm_panel.sv ----
`default_nettype none
// glass: a segment darkens only where its pin is handed to the lcd
module lcdpm_panel (
    // pin steering
    input wire logic [45:0] sel,
    input wire logic [45:0] pix,
    // common 0 view
    output logic [45:0] dark
);
    timeunit 1ns;
    timeprecision 1ps;
    assign dark = sel & pix;
endmodule : lcdpm_panel
`default_nettype wire

// ---- verif/lcdpm_top_tb.sv ----
`default_nettype none
module lcdpm_top_tb;
    import lcdpm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, arst_n = 0, ce = 1, reg_wr = 0, reg_rd = 0, rd_q = 0;
    lcdpm_addr_t reg_addr = 7'h00;
    lcdpm_byte_t reg_wdata = 8'h00, exp_rd = 8'h00;
    logic [7:0] reg_rdata, m [128] = '{default: 8'h00};
    logic [45:0] sel, pix, dark;
    logic [31:0] seed = 32'hA91E;
    int fails = 0, cmp_count = 0;
    lcdpm_top dut_u (.clk, .arst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .segment_line_lcd_sel(sel), .segment_line_com0_pixel(pix));
    lcdpm_panel panel_u (.sel(sel), .pix(pix), .dark(dark));
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic cmp_rd(logic [7:0] g, logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("unexpected read at %0t: got %h exp %h", $time, g, e);
        end
    endtask : cmp_rd
    task automatic cmp_pins(logic [45:0] g, logic [45:0] e);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("unexpected pins at %0t: got %h exp %h", $time, g, e);
        end
    endtask : cmp_pins
    // one bus cycle; the model follows only mapped writes
    task automatic bus(logic w, logic r, lcdpm_addr_t a, lcdpm_byte_t d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        if (w && ce && (a < 7'h06 || (a > 7'h0F && a < 7'h40))) m[a] = (a == 7'h05) ? d & 8'h3F : d;
        rd_q <= r && ce;
        exp_rd <= m[a];
    endtask : bus
    task automatic final_report;
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report
    // compare mid-cycle, clear of the edge updates
    always @(negedge clk) begin
        if (rd_q) cmp_rd(reg_rdata, exp_rd);
        cmp_pins(sel, {m[5][5:0], m[4], m[3], m[2], m[1], m[0]});
        cmp_pins(dark, {30'h0, m[17], m[16]} & sel);
    end
    initial begin
        forever #4 clk = ~clk;
    end
    // hang guard, far beyond the few hundred cycles needed
    initial begin
        #20000;
        fails++;
        final_report;
    end
    // every address written, then every address read back
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int a = 0; a < 128; a++) begin
            seed = lfsr(seed);
            bus(1'b1, 1'b0, a[6:0], seed[7:0]);
        end
        for (int a = 0; a < 128; a++) bus(1'b0, 1'b1, a[6:0], 8'h00);
        bus(1'b1, 1'b0, 7'h05, 8'hFF);
        bus(1'b0, 1'b1, 7'h05, 8'h00);
        // enable low: neither write may land
        ce <= 1'b0;
        bus(1'b1, 1'b0, 7'h00, ~m[0]);
        bus(1'b1, 1'b0, 7'h10, ~m[16]);
        ce <= 1'b1;
        bus(1'b0, 1'b1, 7'h10, 8'h00);
        bus(1'b0, 1'b0, 7'h00, 8'h00);
        // reset in mid-run clears every register
        arst_n <= 1'b0;
        m = '{default: 8'h00};
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        bus(1'b1, 1'b0, 7'h11, 8'hA5);
        bus(1'b0, 1'b1, 7'h11, 8'h00);
        bus(1'b0, 1'b0, 7'h00, 8'h00);
        final_report;
    end
endmodule : lcdpm_top_tb
bind lcdpm_top lcdpm_props props_u (.clk, .arst_n, .ce, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .segment_line_lcd_sel, .segment_line_com0_pixel);
`default_nettype wire
